// file: core/adsq_params.svh
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

`define ADSQ_WORDS        16
`define ADSQ_HALF_WORDS   8
`define ADSQ_ADDR_W       4
`define ADSQ_HALF_ADDR_W  3
`define ADSQ_RESULT_W     12
`define ADSQ_INPUTS       16
`define ADSQ_SEL_W        4
`define ADSQ_CPI_W        4
`define ADSQ_RST_SEL      4'h0
`define ADSQ_RST_RESULT   12'h000
`define ADSQ_RST_COUNT    4'h0
`define ADSQ_LOWER_HALF   1'b0

`endif

// file: core/adsq_pkg.sv
`include "adsq_params.svh"

package adsq_pkg;

  typedef enum logic [1:0] {
    ADSQ_IDLE    = 2'b00,
    ADSQ_SAMPLE  = 2'b01,
    ADSQ_CONVERT = 2'b10
  } adsq_state_t;

  typedef logic [`ADSQ_SEL_W-1:0]    adsq_sel_t;
  typedef logic [`ADSQ_RESULT_W-1:0] adsq_result_t;
  typedef logic [`ADSQ_ADDR_W-1:0]   adsq_addr_t;

endpackage

// file: core/adsq_scan_pick.sv
`include "adsq_params.svh"

module adsq_scan_pick
  import adsq_pkg::*;
(
  input  wire logic [`ADSQ_INPUTS-1:0] scan_select_mask,
  input  wire adsq_sel_t               current_input,
  output adsq_sel_t                    next_input,
  output adsq_sel_t                    lowest_input
);

  // nearest selected input above current, wrapping; itself if nothing else
  always_comb begin
    adsq_sel_t idx;
    idx        = current_input;
    next_input = current_input;
    for (int i = `ADSQ_INPUTS - 1; i >= 1; i--) begin
      idx = current_input + adsq_sel_t'(i);
      if (scan_select_mask[idx]) begin
        next_input = idx;
      end
    end
  end

  // lowest selected input; input zero when the mask is empty
  always_comb begin
    lowest_input = `ADSQ_RST_SEL;
    for (int i = `ADSQ_INPUTS - 1; i >= 0; i--) begin
      if (scan_select_mask[i]) begin
        lowest_input = adsq_sel_t'(i);
      end
    end
  end

endmodule

// file: core/adsq_seq.sv
// Function
// - sample input, convert, store result in next buffer word from word zero
// - count field all ones: interrupt after sixteenth completed conversion
// - split clear: all sixteen words form one buffer, filled in order
// - alternate clear: every sample uses multiplexer A selections only
// - mux A positive select zero routes input zero to positive input
// - mux A negative select clear connects negative reference
// - scan enabled: positive input comes from scan, fixed select ignored
// - full mask scan: one input per conversion, ascending zero to fifteen
// - repeat sample-convert-store until buffer full, then interrupt
// - after interrupt continue; next result to word zero, scan restarts
// - scan disabled: no scan, scan mask ignored
// - only mux A in use: mux B selections ignored
// - count field gives one to sixteen conversions; restart buffer start
// - split set: two eight-word halves alternate per interrupt, lower first
// - status bit shows half being filled: zero lower, one upper
// - auto-sample starts sampling; trigger ends sampling, starts conversion
`include "adsq_params.svh"

module adsq_seq
  import adsq_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    auto_sample_enable,
  input  wire logic                    sample_start,
  input  wire logic                    conv_trigger,
  input  wire logic [`ADSQ_CPI_W-1:0]  conversions_per_interrupt,
  input  wire logic                    buffer_split_enable,
  input  wire logic                    alternate_input_enable,
  input  wire adsq_sel_t               mux_a_positive_select,
  input  wire logic                    mux_a_negative_select,
  input  wire adsq_sel_t               mux_b_positive_select,
  input  wire logic                    mux_b_negative_select,
  input  wire logic                    scan_enable,
  input  wire logic [`ADSQ_INPUTS-1:0] scan_select_mask,
  input  wire logic                    interrupt_flag_clear,
  input  wire logic                    conv_done,
  input  wire adsq_result_t            conv_result,
  input  wire adsq_addr_t              buffer_read_addr,
  output adsq_sel_t                    sh_positive_select,
  output logic                         sh_negative_select,
  output logic                         sampling,
  output logic                         converting,
  output logic                         conv_start,
  output logic                         result_written,
  output adsq_addr_t                   result_write_addr,
  output adsq_result_t                 result_buffer_word,
  output logic                         conversion_interrupt_flag,
  output logic                         sequence_end,
  output logic                         buffer_half_status,
  output logic [`ADSQ_CPI_W-1:0]       sequence_count
);

  adsq_state_t                  state_q;
  adsq_state_t                  state_d;
  logic [`ADSQ_CPI_W-1:0]       count_q;
  logic                         half_q;
  logic                         alt_b_q;
  logic                         alt_b_d;
  adsq_sel_t                    scan_idx_q;
  adsq_sel_t                    scan_idx_d;
  adsq_sel_t                    scan_next;
  adsq_sel_t                    scan_lowest;
  adsq_sel_t                    pos_q;
  logic                         neg_q;
  adsq_sel_t                    pos_d;
  logic                         neg_d;
  logic                         conv_start_q;
  logic                         written_q;
  adsq_addr_t                   waddr_q;
  adsq_result_t                 rdata_q;
  logic                         flag_q;
  logic                         seq_end_q;
  adsq_addr_t                   waddr;
  logic                         start_sample;
  logic                         done_hit;
  logic                         last_conv;
  adsq_result_t                 buffer_mem [`ADSQ_WORDS];

  adsq_scan_pick u_scan_pick (
    .scan_select_mask (scan_select_mask),
    .current_input    (scan_idx_q),
    .next_input       (scan_next),
    .lowest_input     (scan_lowest)
  );

  assign start_sample = auto_sample_enable | sample_start;
  assign done_hit     = (state_q == ADSQ_CONVERT) && conv_done;
  // count field holds conversions minus one
  assign last_conv    = (count_q == conversions_per_interrupt);

  // buffer word address for the result now completing
  always_comb begin
    if (buffer_split_enable) begin
      waddr = {half_q, count_q[`ADSQ_HALF_ADDR_W-1:0]};
    end else begin
      waddr = count_q;
    end
  end

  // input selection latched when sampling begins; at a done edge the
  // phase and pointer move, so the next sample takes their next values
  always_comb begin
    if (alternate_input_enable && alt_b_d) begin
      pos_d = mux_b_positive_select;
      neg_d = mux_b_negative_select;
    end else begin
      // B selections unused on this path
      neg_d = mux_a_negative_select;
      if (scan_enable) begin
        pos_d = scan_idx_d;
      end else begin
        pos_d = mux_a_positive_select;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ADSQ_IDLE: begin
        if (start_sample) begin
          state_d = ADSQ_SAMPLE;
        end
      end
      ADSQ_SAMPLE: begin
        if (conv_trigger) begin
          state_d = ADSQ_CONVERT;
        end
      end
      ADSQ_CONVERT: begin
        if (conv_done) begin
          // continue automatically while auto-sample stays set
          state_d = auto_sample_enable ? ADSQ_SAMPLE : ADSQ_IDLE;
        end
      end
      default: begin
        state_d = ADSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ADSQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // channel held on the sample/hold from start of sample to end of conversion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= `ADSQ_RST_SEL;
      neg_q <= 1'b0;
    end else if (state_d == ADSQ_SAMPLE && state_q != ADSQ_SAMPLE) begin
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= (state_q == ADSQ_SAMPLE) && conv_trigger;
    end
  end

  // conversion counter, restarts at buffer start each interrupt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `ADSQ_RST_COUNT;
    end else if (done_hit) begin
      if (last_conv) begin
        count_q <= `ADSQ_RST_COUNT;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // half toggles per interrupt while split; lower half whenever split is off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= `ADSQ_LOWER_HALF;
    end else if (!buffer_split_enable) begin
      half_q <= `ADSQ_LOWER_HALF;
    end else if (done_hit && last_conv) begin
      half_q <= ~half_q;
    end
  end

  // next A/B phase, sequence always opens with A
  always_comb begin
    alt_b_d = alt_b_q;
    if (!alternate_input_enable) begin
      alt_b_d = 1'b0;
    end else if (done_hit) begin
      alt_b_d = last_conv ? 1'b0 : ~alt_b_q;
    end
  end

  // next scan pointer: lowest selected while a sequence has not begun
  always_comb begin
    scan_idx_d = scan_idx_q;
    if (done_hit) begin
      if (last_conv) begin
        scan_idx_d = scan_lowest;
      end else if (!alternate_input_enable || alt_b_q) begin
        scan_idx_d = scan_next;
      end
    end else if (state_q == ADSQ_IDLE && count_q == `ADSQ_RST_COUNT) begin
      scan_idx_d = scan_lowest;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alt_b_q <= 1'b0;
    end else begin
      alt_b_q <= alt_b_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scan_idx_q <= `ADSQ_RST_SEL;
    end else begin
      scan_idx_q <= scan_idx_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (done_hit) begin
      buffer_mem[waddr] <= conv_result;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `ADSQ_RST_RESULT;
    end else begin
      rdata_q <= buffer_mem[buffer_read_addr];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      written_q <= 1'b0;
      waddr_q   <= `ADSQ_RST_COUNT;
      seq_end_q <= 1'b0;
    end else begin
      written_q <= done_hit;
      seq_end_q <= done_hit && last_conv;
      if (done_hit) begin
        waddr_q <= waddr;
      end
    end
  end

  // sticky flag; a new end of sequence beats a simultaneous clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (done_hit && last_conv) begin
      flag_q <= 1'b1;
    end else if (interrupt_flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  assign sh_positive_select        = pos_q;
  assign sh_negative_select        = neg_q;
  assign sampling                  = (state_q == ADSQ_SAMPLE);
  assign converting                = (state_q == ADSQ_CONVERT);
  assign conv_start                = conv_start_q;
  assign result_written            = written_q;
  assign result_write_addr         = waddr_q;
  assign result_buffer_word        = rdata_q;
  assign conversion_interrupt_flag = flag_q;
  assign sequence_end              = seq_end_q;
  assign buffer_half_status        = half_q;
  assign sequence_count            = count_q;

endmodule

// file: sim/adsq_core_model.sv
module adsq_core_model
  import adsq_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [3:0] dly,
  input  wire logic       conv_start,
  input  wire adsq_sel_t  sh_positive_select,
  output logic            conv_done,
  output adsq_result_t    conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt = 0;
  logic [7:0] n = 8'h00;
  initial begin
    conv_done = 1'b0;
    conv_result = 12'h000;
  end
  // result = serial number and sampled input; line toggles when not valid
  always @(negedge mclk) begin
    if (conv_start)
      cnt = dly + 1;
    conv_done <= (cnt == 1);
    conv_result <= (cnt == 1) ? {n, sh_positive_select} : ~conv_result;
    if (cnt == 1)
      n <= n + 8'h01;
    if (cnt != 0)
      cnt = cnt - 1;
  end
endmodule

// file: sim/adsq_seq_sva.sv
module adsq_seq_chk
  import adsq_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       auto_sample_enable,
  input wire logic       sample_start,
  input wire logic       conv_trigger,
  input wire logic [3:0] conversions_per_interrupt,
  input wire logic       buffer_split_enable,
  input wire logic       conv_done,
  input wire logic       sampling,
  input wire logic       converting,
  input wire logic       conv_start,
  input wire logic       result_written,
  input wire adsq_addr_t result_write_addr,
  input wire logic       sequence_end,
  input wire logic       buffer_half_status,
  input wire logic       conversion_interrupt_flag,
  input wire logic [3:0] sequence_count
);
  logic [2:0] cnt_lo;
  assign cnt_lo = sequence_count[2:0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_trig;
    sampling && conv_trigger;
  endsequence
  sequence s_ack;
    converting && conv_start;
  endsequence
  chk_start_samples: assert property (
    !sampling && !converting && (auto_sample_enable || sample_start) |=> sampling)
    else $error("no sampling after start");
  chk_trig_convert: assert property (s_trig |=> s_ack)
    else $error("no conversion after trigger");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start too long");
  chk_done_store: assert property (converting && conv_done |=> result_written && !converting)
    else $error("result not stored");
  chk_addr_flat: assert property (
    result_written && !buffer_split_enable |-> result_write_addr == $past(sequence_count))
    else $error("wrong word address");
  chk_addr_half: assert property (
    result_written && buffer_split_enable |-> result_write_addr == {$past(buffer_half_status), $past(cnt_lo)})
    else $error("wrong half address");
  chk_seq_end: assert property (
    result_written |-> sequence_end == ($past(sequence_count) == $past(conversions_per_interrupt)))
    else $error("sequence end at wrong count");
  chk_count_wrap: assert property (sequence_end |-> sequence_count == 4'h0 && conversion_interrupt_flag)
    else $error("no restart or flag at end");
  chk_half_flip: assert property (
    sequence_end && buffer_split_enable |-> buffer_half_status != $past(buffer_half_status))
    else $error("half did not alternate");
endmodule

bind adsq_seq adsq_seq_chk u_chk (
  .mclk, .rst_n, .auto_sample_enable, .sample_start, .conv_trigger, .conversions_per_interrupt,
  .buffer_split_enable, .conv_done, .sampling, .converting, .conv_start, .result_written,
  .result_write_addr, .sequence_end, .buffer_half_status, .conversion_interrupt_flag, .sequence_count
);

// file: sim/testbench.sv
module testbench
  import adsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  logic         auto_sample_enable = 1'b0;
  logic         sample_start = 1'b0;
  logic         conv_trigger = 1'b0;
  logic [3:0]   conversions_per_interrupt = 4'h0;
  logic         buffer_split_enable = 1'b0;
  adsq_sel_t    mux_a_positive_select = 4'h0;
  logic         scan_enable = 1'b0;
  logic [15:0]  scan_select_mask = 16'h0000;
  logic         interrupt_flag_clear = 1'b0;
  adsq_addr_t   buffer_read_addr = 4'h0;
  logic [3:0]   dly = 4'h0;
  logic         trig_en = 1'b0;
  logic         alternate_input_enable = 1'b0;
  logic         exp_neg = 1'b0;
  logic         conv_done, sh_negative_select, sampling, converting, conv_start, result_written;
  logic         conversion_interrupt_flag, sequence_end, buffer_half_status;
  adsq_result_t conv_result, result_buffer_word;
  adsq_sel_t    sh_positive_select;
  adsq_addr_t   result_write_addr;
  logic [3:0]   sequence_count;
  int           error_cnt = 0;
  int           total_checks = 0;
  int           nconv = 0;
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  adsq_seq dut (
    .mclk, .rst_n, .auto_sample_enable, .sample_start, .conv_trigger, .conversions_per_interrupt,
    .buffer_split_enable, .alternate_input_enable, .mux_a_positive_select, .mux_a_negative_select(1'b0),
    .mux_b_positive_select(4'h9), .mux_b_negative_select(1'b1), .scan_enable, .scan_select_mask,
    .interrupt_flag_clear, .conv_done, .conv_result, .buffer_read_addr, .sh_positive_select,
    .sh_negative_select, .sampling, .converting, .conv_start, .result_written, .result_write_addr,
    .result_buffer_word, .conversion_interrupt_flag, .sequence_end, .buffer_half_status, .sequence_count
  );
  adsq_core_model u_core (.mclk, .dly, .conv_start, .sh_positive_select, .conv_done, .conv_result);
  always @(negedge mclk)
    conv_trigger <= trig_en && sampling === 1'b1;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic setup(input logic [3:0] cpi, input logic split, input logic scan,
                       input logic [15:0] mask, input adsq_sel_t sel, input logic autos);
    @(negedge mclk);
    rst_n = 1'b0;
    trig_en = 1'b0;
    auto_sample_enable = 1'b0;
    conversions_per_interrupt = cpi;
    buffer_split_enable = split;
    scan_enable = scan;
    scan_select_mask = mask;
    mux_a_positive_select = sel;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    auto_sample_enable = autos;
    trig_en = 1'b1;
  endtask
  // one conversion: selection while converting, then word and end mark
  task automatic step(input adsq_sel_t sel, input adsq_addr_t addr, input logic last);
    int i;
    for (i = 0; i < 100 && conv_start !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    check("start", 1'b1, conv_start);
    check("select", sel, sh_positive_select);
    check("negative", exp_neg, sh_negative_select);
    for (i = 0; i < 100 && result_written !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    check("written", 1'b1, result_written);
    check("address", addr, result_write_addr);
    check("end", last, sequence_end);
    nconv++;
  endtask
  task automatic sc_single();
    int n0;
    dly = 4'h0;
    setup(4'hF, 1'b0, 1'b0, 16'h00F0, 4'h0, 1'b1);
    n0 = nconv;
    for (int k = 0; k < 16; k++)
      step(4'h0, 4'(k), k == 15);
    trig_en = 1'b0;
    check("flag", 1'b1, conversion_interrupt_flag);
    for (int w = 0; w < 16; w++) begin
      @(negedge mclk);
      buffer_read_addr = 4'(w);
      @(posedge mclk);
      #1;
      check("word", {8'(n0 + w), 4'h0}, result_buffer_word);
    end
    @(negedge mclk);
    interrupt_flag_clear = 1'b1;
    @(negedge mclk);
    interrupt_flag_clear = 1'b0;
    check("flag", 1'b0, conversion_interrupt_flag);
  endtask
  task automatic sc_scan_all();
    dly = 4'h5;
    setup(4'hF, 1'b0, 1'b1, 16'hFFFF, 4'h7, 1'b1);
    for (int k = 0; k < 17; k++)
      step(4'(k), 4'(k), k == 15);
    trig_en = 1'b0;
  endtask
  task automatic sc_wrap();
    adsq_sel_t q [6];
    q = '{4'h1, 4'h5, 4'hA, 4'hF, 4'h1, 4'h1};
    dly = 4'h1;
    setup(4'h4, 1'b0, 1'b1, 16'h8422, 4'h3, 1'b1);
    for (int k = 0; k < 6; k++)
      step(q[k], k < 5 ? 4'(k) : 4'h0, k == 4);
    trig_en = 1'b0;
  endtask
  task automatic sc_split();
    dly = 4'h2;
    setup(4'h1, 1'b1, 1'b0, 16'hFFFF, 4'h3, 1'b1);
    for (int k = 0; k < 5; k++) begin
      check("half", k[1], buffer_half_status);
      step(4'h3, {k[1], 2'b00, k[0]}, k[0]);
    end
    trig_en = 1'b0;
  endtask
  task automatic sc_alt();
    adsq_sel_t q [5];
    q = '{4'h2, 4'h9, 4'h2, 4'h9, 4'h2};
    dly = 4'h3;
    @(negedge mclk);
    alternate_input_enable = 1'b1;
    setup(4'h3, 1'b0, 1'b0, 16'h0000, 4'h2, 1'b1);
    for (int k = 0; k < 5; k++) begin
      exp_neg = k[0];
      step(q[k], k < 4 ? 4'(k) : 4'h0, k == 3);
    end
    exp_neg = 1'b0;
    trig_en = 1'b0;
    @(negedge mclk);
    alternate_input_enable = 1'b0;
  endtask
  task automatic sc_manual();
    dly = 4'h0;
    setup(4'h0, 1'b0, 1'b0, 16'h0000, 4'hC, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk);
      sample_start = 1'b1;
      @(negedge mclk);
      sample_start = 1'b0;
      step(4'hC, 4'h0, 1'b1);
      repeat (3) @(negedge mclk);
      check("sampling", 1'b0, sampling);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    sc_single();
    sc_scan_all();
    sc_wrap();
    sc_split();
    sc_alt();
    sc_manual();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
endmodule
